// ==== dv/core_event_src.sv ====
// partner model: reset sources and the core that reloads its counter
// assumes the bench calls fire() and pcLoad_q is a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none

module core_event_src (
	// clock and core strobe
	input wire core_clk,
	input wire pcLoad_q,
	input wire [20:0] pcValue_q,
	// reset and wake events
	output wire porEvt,
	output wire borEvt,
	output wire clearEvt,
	output wire watchdogTimeout,
	output wire resetInstrEvt,
	output wire stackFullEvt,
	output wire stackUnderEvt,
	output wire irqWakeEvt,
	// core levels
	output logic irqHighPrio,
	output logic [2:0] irqSourceIdx,
	output logic [1:0] powerMode,
	output logic [20:0] pcIn,
	output logic [7:0] portPins
);
	logic [7:0] evtVec;

	// one bit per source, bit 0 power-on up to bit 7 interrupt wake
	assign {irqWakeEvt, stackUnderEvt, stackFullEvt, resetInstrEvt, watchdogTimeout, clearEvt, borEvt, porEvt} = evtVec;

	// quiet levels from time zero; pin pattern sets bit 7 but not bit 6 of the two masked bits
	initial begin
		evtVec = 8'h00;
		irqHighPrio = 1'b0;
		irqSourceIdx = 3'd0;
		powerMode = 2'b00;
		pcIn = 21'h0_0000;
		portPins = 8'hA5;
	end

	// core jumps to whatever address it is handed
	always @(posedge core_clk) begin
		if (pcLoad_q) pcIn <= pcValue_q;
	end

	// levels settle one edge ahead of the pulse so they are valid with it
	task automatic fire(input logic [7:0] m, input logic [1:0] pm, input logic hi, input logic [2:0] src,
		input logic [20:0] pc);
		@(posedge core_clk);
		powerMode <= pm;
		irqHighPrio <= hi;
		irqSourceIdx <= src;
		pcIn <= pc;
		@(posedge core_clk);
		evtVec <= m;
		@(posedge core_clk);
		evtVec <= 8'h00;
	endtask
endmodule
`default_nettype wire

// ==== dv/reset_state_initializer_assertions.sv ====
// checker: reset, warm-reset and wake-up state seen at the core-facing ports
// assumes events are one-cycle pulses sampled at posedge core_clk
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_initializer_consts.vh"

module reset_state_initializer_assertions (
	// clock and reset
	input wire core_clk,
	input wire sys_rst,
	// events and levels
	input wire porEvt,
	input wire borEvt,
	input wire clearEvt,
	input wire watchdogTimeout,
	input wire resetInstrEvt,
	input wire stackFullEvt,
	input wire stackUnderEvt,
	input wire irqWakeEvt,
	input wire irqHighPrio,
	input wire [2:0] irqSourceIdx,
	input wire [1:0] powerMode,
	input wire [20:0] pcIn,
	// core-facing state
	input wire pcLoad_q,
	input wire [20:0] pcValue_q,
	input wire [20:0] stackTop_q,
	input wire [4:0] stackPtr_q,
	input wire [7:0] wakeFlagsOut_q,
	input wire [7:0] portDirOut_q
);
	// ----------------------------------------------------------------
	// event decode
	// ----------------------------------------------------------------
	// watchdog is a reset only outside idle and sleep, else a wake
	wire otherEvt = porEvt | borEvt | clearEvt | watchdogTimeout | resetInstrEvt | stackFullEvt | stackUnderEvt;
	wire warmEvt = !porEvt && !borEvt && (clearEvt || resetInstrEvt || (watchdogTimeout && !powerMode[1]));
	wire [20:0] vecSel = irqHighPrio ? `VECTOR_HIGH : `VECTOR_LOW;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// a lone interrupt wake, then a quiet cycle for the late flag copy
	sequence wakeOnly;
		irqWakeEvt && !otherEvt;
	endsequence
	sequence wakeSettled;
		wakeOnly ##1 (!otherEvt && !irqWakeEvt);
	endsequence

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	push_pc_a: assert property (wakeOnly |=> (stackPtr_q != $past(stackPtr_q) |-> stackTop_q == $past(pcIn)))
		else $error("wake push lost the program counter");
	ptr_step_a: assert property (wakeOnly |=> pcLoad_q && (stackPtr_q == $past(stackPtr_q) + 5'd1 ||
		(stackPtr_q == $past(stackPtr_q) && pcValue_q == $past(pcIn) + 21'd2)))
		else $error("wake stack pointer step wrong");
	vector_load_a: assert property (wakeOnly |=> (stackPtr_q == $past(stackPtr_q) + 5'd1) == (pcValue_q == $past(vecSel)))
		else $error("vector load does not match push");
	wake_flag_a: assert property (wakeSettled |=> wakeFlagsOut_q[$past(irqSourceIdx, 2)])
		else $error("wake source flag not set");
	port_mask_a: assert property ($fell(sys_rst) |-> ##[1:3] portDirOut_q == 8'h3F)
		else $error("upper port bits not masked after reset");
	power_init_a: assert property (porEvt || borEvt |=> pcLoad_q && pcValue_q == `PC_RESET && stackPtr_q == 5'd0)
		else $error("power reset state wrong");
	shared_init_a: assert property (warmEvt |=> pcLoad_q && pcValue_q == `PC_RESET && stackPtr_q == 5'd0 && stackTop_q == 21'd0)
		else $error("warm reset state wrong");
	hold_state_a: assert property (!otherEvt && !irqWakeEvt |=> $stable(stackTop_q) && $stable(stackPtr_q) && !pcLoad_q)
		else $error("stack state moved without an event");
endmodule

bind reset_state_initializer reset_state_initializer_assertions u_chk (.core_clk, .sys_rst, .porEvt, .borEvt,
	.clearEvt, .watchdogTimeout, .resetInstrEvt, .stackFullEvt, .stackUnderEvt, .irqWakeEvt, .irqHighPrio,
	.irqSourceIdx, .powerMode, .pcIn, .pcLoad_q, .pcValue_q, .stackTop_q, .stackPtr_q, .wakeFlagsOut_q, .portDirOut_q);
`default_nettype wire

// ==== dv/reset_state_initializer_tb.sv ====
// testbench: bus-level tests of reset causes, wake pushes, port masking and interrupt
// assumes the partner model drives all events and core levels
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_initializer_consts.vh"

module reset_state_initializer_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	// always ready for answers; full-word writes only
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic [3:0] wstrb = 4'hF;
	wire awready, wready, bvalid, arready, rvalid, pcLoad_q, irq_q, irqHighPrio;
	wire porEvt, borEvt, clearEvt, watchdogTimeout, resetInstrEvt, stackFullEvt, stackUnderEvt, irqWakeEvt;
	wire [1:0] bresp, rresp, powerMode;
	wire [31:0] rdata;
	wire [20:0] pcValue_q, stackTop_q, pcIn;
	wire [4:0] stackPtr_q;
	wire [2:0] irqSourceIdx;
	wire [7:0] wakeFlagsOut_q, portLatchOut_q, portDirOut_q, portPins;
	int err_total = 0;
	int check_count = 0;
	int expPtr = 0;
	// event table: pulse, power mode, control, cause, outcome (0 reset, 1 wake, 2 flag only)
	logic [7:0] tEvt [10] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h20, 8'h40, 8'h40, 8'h02, 8'h01};
	// idle and full power appear too, so every decoded power mode is reached
	logic [1:0] tPm [10] = '{2'b01, 2'b10, 2'b00, 2'b11, 2'b01, 2'b01, 2'b01, 2'b01, 2'b01, 2'b01};
	logic [7:0] tCtl [10] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h01, 8'h05, 8'h05};
	logic [11:0] tCause [10] = '{12'h01B, 12'h01B, 12'h013, 12'h013, 12'h003, 12'h213, 12'h113, 12'h113, 12'h01E, 12'h01C};
	int tKind [10] = '{0, 0, 0, 1, 0, 0, 0, 2, 0, 0};

	reset_state_initializer u_dut (.core_clk, .sys_rst, .porEvt, .borEvt, .clearEvt, .watchdogTimeout,
		.resetInstrEvt, .stackFullEvt, .stackUnderEvt, .irqWakeEvt, .irqHighPrio, .irqSourceIdx, .powerMode, .pcIn,
		.portPins, .pcLoad_q, .pcValue_q, .stackTop_q, .stackPtr_q, .wakeFlagsOut_q, .portLatchOut_q, .portDirOut_q,
		.irq_q, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	core_event_src u_src (.core_clk, .pcLoad_q, .pcValue_q, .porEvt, .borEvt, .clearEvt, .watchdogTimeout,
		.resetInstrEvt, .stackFullEvt, .stackUnderEvt, .irqWakeEvt, .irqHighPrio, .irqSourceIdx, .powerMode, .pcIn,
		.portPins);

	// 40 MHz core clock
	always #12.5 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk(bresp, 2'b00, "bresp");
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		chk(rresp, er, "rresp");
		chk(rdata, e, "rdata");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdc(`OFS_CAUSE, 32'h1C, 2'b00);
		rdc(`OFS_CTRL, 32'h04, 2'b00);
		rdc(`OFS_PORT_DIR, 32'h3F, 2'b00);
		rdc(8'h40, 32'h0, 2'b11);
		$display("reset test done");
		// upper port bits only while the oscillator leaves them free
		axiWr(`OFS_PORT_LATCH, 32'hFF);
		rdc(`OFS_PORT_LATCH, 32'h3F, 2'b00);
		rdc(`OFS_PORT_IN, 32'h25, 2'b00);
		chk(portLatchOut_q, 32'h3F, "latch out");
		axiWr(`OFS_CTRL, 32'h24);
		axiWr(`OFS_PORT_LATCH, 32'hFF);
		rdc(`OFS_PORT_LATCH, 32'hFF, 2'b00);
		rdc(`OFS_PORT_DIR, 32'hFF, 2'b00);
		rdc(`OFS_PORT_IN, 32'hA5, 2'b00);
		chk(portDirOut_q, 32'hFF, "dir out");
		axiWr(`OFS_CTRL, 32'h04);
		$display("port mask test done");
		// wake with both enables clear resumes after the sleep
		u_src.fire(8'h80, 2'b11, 1'b1, 3'd3, 21'h100);
		#1;
		chk(pcValue_q, 32'h102, "pc");
		chk(stackPtr_q, 32'h0, "ptr");
		rdc(`OFS_WAKE_FLAGS, 32'h08, 2'b00);
		rdc(`OFS_CAUSE, 32'h18, 2'b00);
		// high then low priority vector, each pushing the pc
		for (int i = 0; i < 2; i++) begin
			axiWr(`OFS_CTRL, i ? 32'h06 : 32'h05);
			u_src.fire(8'h80, 2'b11, !i, 3'd4, 21'h200 + i);
			#1;
			expPtr++;
			chk(pcValue_q, i ? `VECTOR_LOW : `VECTOR_HIGH, "vector");
			chk(stackTop_q, 32'h200 + i, "top");
			chk(stackPtr_q, expPtr[4:0], "ptr");
		end
		axiWr(`OFS_STACK_PTR, 32'h1F);
		rdc(`OFS_STACK_PTR, expPtr, 2'b00);
		$display("wake test done");
		// every reset class after a push, cause rewritten first
		for (int i = 0; i < 10; i++) begin
			axiWr(`OFS_CTRL, {24'h0, tCtl[i]});
			u_src.fire(8'h80, tPm[i], 1'b1, 3'd1, 21'h400);
			expPtr++;
			axiWr(`OFS_CAUSE, 32'h13);
			u_src.fire(tEvt[i], tPm[i], 1'b0, 3'd1, 21'h500);
			#1;
			if (tKind[i] == 0) expPtr = 0;
			chk(pcLoad_q, tKind[i] != 2, "load");
			chk(stackPtr_q, expPtr[4:0], "ptr");
			chk(stackTop_q, tKind[i] ? 32'h400 : 32'h0, "top");
			if (tKind[i] < 2) chk(pcValue_q, tKind[i] ? 32'h502 : 32'h0, "pc");
			rdc(`OFS_CAUSE, tCause[i], 2'b00);
			if (tKind[i] == 0) rdc(`OFS_CTRL, tCtl[i] & 8'h3C, 2'b00);
		end
		$display("reset class test done");
		// interrupt wake status: unmasked, masked, cleared
		axiWr(`OFS_IRQ_MASK, 32'h10);
		repeat (2) @(posedge core_clk);
		chk(irq_q, 32'h1, "irq on");
		axiWr(`OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge core_clk);
		chk(irq_q, 32'h0, "irq masked");
		axiWr(`OFS_IRQ_MASK, 32'h10);
		axiWr(`OFS_IRQ_STATUS, 32'h10);
		repeat (2) @(posedge core_clk);
		chk(irq_q, 32'h0, "irq cleared");
		$display("interrupt test done");
		end_sim();
	end

	// hang guard, far beyond the few hundred cycles the tests take
	initial begin
		#200_000;
		err_total++;
		end_sim();
	end
endmodule
`default_nettype wire

// ==== rtl/port_high_mask.v ====
// masks the two upper port bits when the oscillator mode claims their pins
// assumes a purely combinational use; the caller registers the result
`timescale 1ns/1ps
`default_nettype none

module port_high_mask (
	// value and enable
	input wire [7:0] rawValue,
	input wire pinsFree,
	// masked result
	output wire [7:0] maskedValue
);

	// disabled bits read as zero
	assign maskedValue = {rawValue[7:6] & {2{pinsFree}}, rawValue[5:0]};

endmodule

`default_nettype wire

// ==== rtl/reset_state_initializer.v ====
// top of the reset and wake-up state initializer with its AXI4-Lite register slave
// assumes event inputs are one-cycle pulses synchronous to core_clk from the reset sources and core
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_initializer_consts.vh"

module reset_state_initializer (
	// clock and reset
	input wire core_clk,
	input wire sys_rst,
	// reset and wake events
	input wire porEvt,
	input wire borEvt,
	input wire clearEvt,
	input wire watchdogTimeout,
	input wire resetInstrEvt,
	input wire stackFullEvt,
	input wire stackUnderEvt,
	input wire irqWakeEvt,
	input wire irqHighPrio,
	input wire [2:0] irqSourceIdx,
	input wire [1:0] powerMode,
	input wire [20:0] pcIn,
	// first port pins
	input wire [7:0] portPins,
	// core-facing state
	output reg pcLoad_q,
	output reg [20:0] pcValue_q,
	output reg [20:0] stackTop_q,
	output reg [4:0] stackPtr_q,
	output reg [7:0] wakeFlagsOut_q,
	output reg [7:0] portLatchOut_q,
	output reg [7:0] portDirOut_q,
	output reg irq_q,
	// axi4-lite write channels
	input wire [7:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// axi4-lite read channels
	input wire [7:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg gieHigh_q;
	reg gieLow_q;
	reg stackRstEn_q;
	reg [1:0] oscMode_q;
	reg riN_q;
	reg timeout_q;
	reg powerDown_q;
	reg porN_q;
	reg borN_q;
	reg stackFull_q;
	reg stackUnder_q;
	reg [7:0] portLatch_q;
	reg [7:0] portDir_q;
	reg [7:0] portIn_q;
	reg [5:0] irqMask_q;
	reg awHeld_q;
	reg wHeld_q;
	reg [7:0] wrAddr_q;
	reg [31:0] wrData_q;
	reg [3:0] wrStrb_q;
	wire [5:0] irqStatus;
	wire [7:0] wakeFlags;
	wire [7:0] latchMasked;
	wire [7:0] dirMasked;
	wire [7:0] pinsMasked;
	wire pinsFree;

	// ----------------------------------------------------------------
	// event classification
	// ----------------------------------------------------------------
	wire sleepy = (powerMode == `PMODE_IDLE) || (powerMode == `PMODE_SLEEP);
	wire stackFullRst = stackFullEvt & stackRstEn_q;
	wire stackUnderRst = stackUnderEvt & stackRstEn_q;
	wire watchdogRst = watchdogTimeout & ~sleepy;
	wire watchdogWake = watchdogTimeout & sleepy;
	// all warm sources fold into one class sharing one init set
	wire warmEvt = clearEvt | watchdogRst | resetInstrEvt | stackFullRst | stackUnderRst;
	wire anyReset = porEvt | borEvt | warmEvt;
	wire intWake = irqWakeEvt & ~anyReset;
	wire wdWake = watchdogWake & ~anyReset;
	wire takeVector = intWake & (gieHigh_q | gieLow_q);
	wire stackErrOnly = (stackFullEvt | stackUnderEvt) & ~stackRstEn_q;

	// ----------------------------------------------------------------
	// bus write decode
	// ----------------------------------------------------------------
	wire wrEn = awHeld_q & wHeld_q & ~bvalid;
	wire [31:0] strbMask = {{8{wrStrb_q[3]}}, {8{wrStrb_q[2]}}, {8{wrStrb_q[1]}}, {8{wrStrb_q[0]}}};
	wire [31:0] wrBits = wrData_q & strbMask;
	wire wrCtrl = wrEn && (wrAddr_q == `OFS_CTRL);
	wire wrCause = wrEn && (wrAddr_q == `OFS_CAUSE);
	wire wrWake = wrEn && (wrAddr_q == `OFS_WAKE_FLAGS);
	wire wrIrqStat = wrEn && (wrAddr_q == `OFS_IRQ_STATUS);
	wire wrIrqMask = wrEn && (wrAddr_q == `OFS_IRQ_MASK);
	wire wrLatch = wrEn && (wrAddr_q == `OFS_PORT_LATCH);
	wire wrDir = wrEn && (wrAddr_q == `OFS_PORT_DIR);
	reg wrMapped;

	// write address check; read-only offsets accept and ignore
	always @* begin
		if (wrAddr_q == `OFS_CTRL || wrAddr_q == `OFS_CAUSE || wrAddr_q == `OFS_STACK_TOP) begin
			wrMapped = 1'b1;
		end else if (wrAddr_q == `OFS_STACK_PTR || wrAddr_q == `OFS_WAKE_FLAGS) begin
			wrMapped = 1'b1;
		end else if (wrAddr_q == `OFS_IRQ_STATUS || wrAddr_q == `OFS_IRQ_MASK) begin
			wrMapped = 1'b1;
		end else if (wrAddr_q == `OFS_PORT_LATCH || wrAddr_q == `OFS_PORT_DIR || wrAddr_q == `OFS_PORT_IN) begin
			wrMapped = 1'b1;
		end else begin
			wrMapped = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// flag banks and port masking
	// ----------------------------------------------------------------
	wire [5:0] irqSet = {stackErrOnly | stackFullRst | stackUnderRst, intWake, wdWake, warmEvt & ~porEvt & ~borEvt,
		borEvt & ~porEvt, porEvt};
	wire [7:0] wakeSet = intWake ? (8'h01 << irqSourceIdx) : 8'h00;
	// any reset wipes the wake flags; a wake in the same cycle cannot occur
	wire [7:0] wakeClr = (wrWake ? wrBits[7:0] : 8'h00) | (anyReset ? 8'hFF : 8'h00);

	sticky_flags #(.WIDTH(6)) irqFlags (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.setBits(irqSet),
		.clrBits(wrIrqStat ? wrBits[5:0] : 6'h00),
		.flags_q(irqStatus)
	);

	sticky_flags #(.WIDTH(8)) wakeFlagBank (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.setBits(wakeSet),
		.clrBits(wakeClr),
		.flags_q(wakeFlags)
	);

	assign pinsFree = (oscMode_q == `OSC_MODE_PINS_FREE);

	port_high_mask latchMask (
		.rawValue(portLatch_q),
		.pinsFree(pinsFree),
		.maskedValue(latchMasked)
	);

	port_high_mask dirMask (
		.rawValue(portDir_q),
		.pinsFree(pinsFree),
		.maskedValue(dirMasked)
	);

	port_high_mask pinMask (
		.rawValue(portPins),
		.pinsFree(pinsFree),
		.maskedValue(pinsMasked)
	);

	// ----------------------------------------------------------------
	// reset and wake sequencing
	// ----------------------------------------------------------------
	// software writes come first so a hardware event in the same cycle wins
	always @(posedge core_clk) begin
		if (sys_rst) begin
			pcLoad_q <= 1'b0;
			pcValue_q <= `PC_RESET;
			stackTop_q <= 21'h0_0000;
			stackPtr_q <= 5'h00;
			gieHigh_q <= 1'b0;
			gieLow_q <= 1'b0;
			stackRstEn_q <= `CTRL_STACK_RST_EN_RESET;
			oscMode_q <= 2'b00;
			riN_q <= 1'b1;
			timeout_q <= 1'b1;
			powerDown_q <= 1'b1;
			porN_q <= 1'b0;
			borN_q <= 1'b0;
			stackFull_q <= 1'b0;
			stackUnder_q <= 1'b0;
			portLatch_q <= 8'h00;
			portDir_q <= `PORT_DIR_RESET;
			irqMask_q <= 6'h00;
		end else begin
			pcLoad_q <= 1'b0;
			if (wrCtrl) begin
				if (wrStrb_q[0]) begin
					gieHigh_q <= wrData_q[`CTRL_GIE_HIGH];
					gieLow_q <= wrData_q[`CTRL_GIE_LOW];
					stackRstEn_q <= wrData_q[`CTRL_STACK_RST_EN];
					oscMode_q <= wrData_q[`CTRL_OSC_HI:`CTRL_OSC_LO];
				end
			end
			// firmware rearms the cause bits; timeout and power-down are hardware only
			if (wrCause) begin
				if (wrStrb_q[0]) begin
					borN_q <= wrData_q[`CAUSE_BOR_N];
					porN_q <= wrData_q[`CAUSE_POR_N];
					riN_q <= wrData_q[`CAUSE_RI_N];
				end
				if (wrStrb_q[1]) begin
					stackUnder_q <= wrData_q[`CAUSE_STK_UNDER];
					stackFull_q <= wrData_q[`CAUSE_STK_FULL];
				end
			end
			if (wrIrqMask && wrStrb_q[0]) begin
				irqMask_q <= wrData_q[5:0];
			end
			if (wrLatch && wrStrb_q[0]) begin
				portLatch_q <= wrData_q[7:0];
			end
			if (wrDir && wrStrb_q[0]) begin
				portDir_q <= wrData_q[7:0];
			end
			// a stack error with resets disabled only records itself
			if (stackErrOnly) begin
				if (stackFullEvt) begin
					stackFull_q <= 1'b1;
				end
				if (stackUnderEvt) begin
					stackUnder_q <= 1'b1;
				end
			end
			// bits not named in each branch keep their value
			if (porEvt) begin
				pcLoad_q <= 1'b1;
				pcValue_q <= `PC_RESET;
				stackTop_q <= 21'h0_0000;
				stackPtr_q <= 5'h00;
				gieHigh_q <= 1'b0;
				gieLow_q <= 1'b0;
				riN_q <= 1'b1;
				timeout_q <= 1'b1;
				powerDown_q <= 1'b1;
				porN_q <= 1'b0;
				borN_q <= 1'b0;
				stackFull_q <= 1'b0;
				stackUnder_q <= 1'b0;
			end else if (borEvt) begin
				pcLoad_q <= 1'b1;
				pcValue_q <= `PC_RESET;
				stackTop_q <= 21'h0_0000;
				stackPtr_q <= 5'h00;
				gieHigh_q <= 1'b0;
				gieLow_q <= 1'b0;
				riN_q <= 1'b1;
				timeout_q <= 1'b1;
				powerDown_q <= 1'b1;
				borN_q <= 1'b0;
			end else if (warmEvt) begin
				// one shared init set, then per-source cause bits
				pcLoad_q <= 1'b1;
				pcValue_q <= `PC_RESET;
				stackTop_q <= 21'h0_0000;
				stackPtr_q <= 5'h00;
				gieHigh_q <= 1'b0;
				gieLow_q <= 1'b0;
				stackFull_q <= 1'b0;
				stackUnder_q <= 1'b0;
				if (resetInstrEvt) begin
					riN_q <= 1'b0;
				end
				if (clearEvt && powerMode != `PMODE_FULL) begin
					timeout_q <= 1'b1;
				end
				if (clearEvt && sleepy) begin
					powerDown_q <= 1'b0;
				end
				if (watchdogRst) begin
					timeout_q <= 1'b0;
				end
				if (stackFullRst) begin
					stackFull_q <= 1'b1;
				end
				if (stackUnderRst) begin
					stackUnder_q <= 1'b1;
				end
			end else if (intWake || wdWake) begin
				pcLoad_q <= 1'b1;
				powerDown_q <= 1'b0;
				if (wdWake) begin
					timeout_q <= 1'b0;
				end
				if (takeVector) begin
					stackTop_q <= pcIn;
					stackPtr_q <= stackPtr_q + 5'h01;
					pcValue_q <= irqHighPrio ? `VECTOR_HIGH : `VECTOR_LOW;
				end else begin
					pcValue_q <= pcIn + `PC_STEP;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// all visible port state passes through the mask before leaving
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wakeFlagsOut_q <= 8'h00;
			portLatchOut_q <= 8'h00;
			portDirOut_q <= 8'h00;
			portIn_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			wakeFlagsOut_q <= wakeFlags;
			portLatchOut_q <= latchMasked;
			portDirOut_q <= dirMasked;
			portIn_q <= pinsMasked;
			irq_q <= |(irqStatus & irqMask_q);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	// address and data are captured independently, then retired together
	always @(posedge core_clk) begin
		if (sys_rst) begin
			awready <= 1'b1;
			wready <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			wrAddr_q <= 8'h00;
			wrData_q <= 32'h0000_0000;
			wrStrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else begin
			if (awready && awvalid) begin
				awready <= 1'b0;
				awHeld_q <= 1'b1;
				wrAddr_q <= {awaddr[7:2], 2'b00};
			end
			if (wready && wvalid) begin
				wready <= 1'b0;
				wHeld_q <= 1'b1;
				wrData_q <= wdata;
				wrStrb_q <= wstrb;
			end
			if (wrEn) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wrMapped ? `RESP_OKAY : `RESP_DECERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	reg [31:0] rdMux;
	reg rdMapped;
	wire [7:0] rdAddr = {araddr[7:2], 2'b00};

	// read data select
	always @* begin
		rdMux = 32'h0000_0000;
		rdMapped = 1'b1;
		if (rdAddr == `OFS_CTRL) begin
			rdMux = {26'h000_0000, oscMode_q, 1'b0, stackRstEn_q, gieLow_q, gieHigh_q};
		end else if (rdAddr == `OFS_CAUSE) begin
			rdMux = {22'h00_0000, stackFull_q, stackUnder_q, 3'b000, riN_q, timeout_q, powerDown_q, porN_q, borN_q};
		end else if (rdAddr == `OFS_STACK_TOP) begin
			rdMux = {11'h000, stackTop_q};
		end else if (rdAddr == `OFS_STACK_PTR) begin
			rdMux = {27'h000_0000, stackPtr_q};
		end else if (rdAddr == `OFS_WAKE_FLAGS) begin
			rdMux = {24'h00_0000, wakeFlags};
		end else if (rdAddr == `OFS_IRQ_STATUS) begin
			rdMux = {26'h000_0000, irqStatus};
		end else if (rdAddr == `OFS_IRQ_MASK) begin
			rdMux = {26'h000_0000, irqMask_q};
		end else if (rdAddr == `OFS_PORT_LATCH) begin
			rdMux = {24'h00_0000, latchMasked};
		end else if (rdAddr == `OFS_PORT_DIR) begin
			rdMux = {24'h00_0000, dirMasked};
		end else if (rdAddr == `OFS_PORT_IN) begin
			rdMux = {24'h00_0000, portIn_q};
		end else begin
			rdMapped = 1'b0;
		end
	end

	// one read in flight; data frozen until rready
	always @(posedge core_clk) begin
		if (sys_rst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
		end else begin
			if (arready && arvalid) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rdMux;
				rresp <= rdMapped ? `RESP_OKAY : `RESP_DECERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/reset_state_initializer_consts.vh ====
// constants for the reset and wake-up state initializer: offsets, fields, reset values
// assumes a 32-bit AXI4-Lite register bus with byte addresses and an 8-bit address field
`ifndef RESET_STATE_INITIALIZER_CONSTS_VH
`define RESET_STATE_INITIALIZER_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CAUSE 8'h04
`define OFS_STACK_TOP 8'h08
`define OFS_STACK_PTR 8'h0C
`define OFS_WAKE_FLAGS 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_PORT_LATCH 8'h1C
`define OFS_PORT_DIR 8'h20
`define OFS_PORT_IN 8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_GIE_HIGH 0
`define CTRL_GIE_LOW 1
`define CTRL_STACK_RST_EN 2
`define CTRL_OSC_LO 4
`define CTRL_OSC_HI 5
`define CAUSE_BOR_N 0
`define CAUSE_POR_N 1
`define CAUSE_PD 2
`define CAUSE_TO 3
`define CAUSE_RI_N 4
`define CAUSE_STK_UNDER 8
`define CAUSE_STK_FULL 9
`define IRQ_POR 0
`define IRQ_BOR 1
`define IRQ_WARM 2
`define IRQ_WD_WAKE 3
`define IRQ_INT_WAKE 4
`define IRQ_STACK_ERR 5

// ----------------------------------------------------------------
// reset values, encodings, vectors
// ----------------------------------------------------------------
`define CTRL_STACK_RST_EN_RESET 1'b1
`define PORT_DIR_RESET 8'hFF
`define OSC_MODE_PINS_FREE 2'b10
`define PMODE_FULL 2'b00
`define PMODE_RUN 2'b01
`define PMODE_IDLE 2'b10
`define PMODE_SLEEP 2'b11
`define PC_RESET 21'h0_0000
`define VECTOR_HIGH 21'h0_0008
`define VECTOR_LOW 21'h0_0018
`define PC_STEP 21'h0_0002
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ==== rtl/sticky_flags.v ====
// parameterised set-wins sticky flag bank
// assumes set and clear vectors are one-cycle pulses on core_clk
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire core_clk,
	input wire sys_rst,
	// set and clear vectors
	input wire [WIDTH-1:0] setBits,
	input wire [WIDTH-1:0] clrBits,
	// flag state
	output reg [WIDTH-1:0] flags_q
);

	// set wins over a clear in the same cycle, so no event is lost
	always @(posedge core_clk) begin
		if (sys_rst) begin
			flags_q <= {WIDTH{1'b0}};
		end else begin
			flags_q <= (flags_q & ~clrBits) | setBits;
		end
	end

endmodule

`default_nettype wire
